// file: port_pin_consts.svh
// constants for the port pin override logic and its peripheral end
`ifndef PORT_PIN_CONSTS_SVH
`define PORT_PIN_CONSTS_SVH

// ----------------------------------------------------------------
// port shape
// ----------------------------------------------------------------
`define PORT_PINS            8
`define PIN_SIX              6
`define PIN_SEVEN            7

// ----------------------------------------------------------------
// device register indexes on its own register port
// ----------------------------------------------------------------
`define REG_PIN_INPUT        2'h0
`define REG_PIN_DIRECTION    2'h1
`define REG_PIN_OUTPUT       2'h2
`define REG_MCU_CONTROL      2'h3

// ----------------------------------------------------------------
// device register fields and reset values
// ----------------------------------------------------------------
`define MCU_PUD_BIT          4
`define PORT_RESET           8'h00
`define MCU_CONTROL_RESET    8'h00

// ----------------------------------------------------------------
// peripheral end apb map (byte addresses)
// ----------------------------------------------------------------
`define APB_FUNC_ENABLE      12'h000
`define APB_PIN_CHANGE       12'h004
`define APB_PIN_STATUS       12'h008

// function enable register fields
`define FE_TIMER0_A          0
`define FE_TIMER1_C          1
`define FE_TIMER1_B          2
`define FE_FAST_B            3
`define FE_RTS               4
`define FE_TIMER1_A          5
`define FE_SPI_MASTER        6

// pin change register fields
`define PC_MASK_LSB          0
`define PC_ENABLE_BIT        8

`define APB_ZERO             32'h0000_0000

`endif

// file: port_pin_pkg.sv
// types shared by the port pin override logic and its peripheral end
`default_nettype none
package port_pin_pkg;
	typedef logic [7:0] port_bits_t;
	typedef logic [1:0] reg_index_t;
endpackage : port_pin_pkg
`default_nettype wire

// file: port_override_if.sv
// override signal bundle between peripheral modules and the port pin logic
`timescale 1ns/1ps
`default_nettype none
interface port_override_if;
	import port_pin_pkg::*;
	port_bits_t pullup_override_enable;
	port_bits_t pullup_override_value;
	port_bits_t direction_override_enable;
	port_bits_t direction_override_value;
	port_bits_t value_override_enable;
	port_bits_t value_override_value;
	port_bits_t toggle_override_enable;
	port_bits_t input_enable_override_enable;
	port_bits_t input_enable_override_value;
	port_bits_t alt_function_raw_input;

	modport device (
		input  pullup_override_enable,
		input  pullup_override_value,
		input  direction_override_enable,
		input  direction_override_value,
		input  value_override_enable,
		input  value_override_value,
		input  toggle_override_enable,
		input  input_enable_override_enable,
		input  input_enable_override_value,
		output alt_function_raw_input
	);

	modport peripheral (
		output pullup_override_enable,
		output pullup_override_value,
		output direction_override_enable,
		output direction_override_value,
		output value_override_enable,
		output value_override_value,
		output toggle_override_enable,
		output input_enable_override_enable,
		output input_enable_override_value,
		input  alt_function_raw_input
	);
endinterface : port_override_if
`default_nettype wire

// file: port_pin_alt_function_override.sv
// port pin logic: general i/o registers with alternate function overrides
//
// Contract
// R1: pull-up follows override value, else 0b010 decode
// R2: override value alone switches pull-up on/off
// R3: driver enable from override value or direction
// R4: direction override value alone switches driver
// R5: driven level from value override or output
// R6: value override masks the output register bit
// R7: toggle override inverts the output register bit
// R8: input enable follows override, else sleep state
// R9: input enable override ignores sleep state
// R10: raw input tapped before the pin synchroniser
// R11: peripherals synchronise raw input unless clock
// R12: peripherals generate overrides, present to pins
// R13: pull-up disable bit 4 kills all pull-ups
// R14: pin 7 carries timer0 compare A output
// R15: pin 7 carries timer1 compare C output
// R16: pin 6 carries timer1 compare B output
// R17: pin 6 carries fast timer compare B
// R18: pins 7 and 6 feed pin-change sources
// R19: pin 7 carries uart request-to-send output
// R20: pins 0-5 carry spi, pin-change, timer alternates
// R21: direction bit one output, zero input
// R22: writing one to input bit toggles output
// R23: unused override enables tied inactive
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_consts.svh"
module port_pin_alt_function_override
	import port_pin_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_nrst,
	// register port
	input  wire logic       i_reg_write,
	input  wire reg_index_t i_reg_index,
	input  wire port_bits_t i_reg_wdata,
	output logic            o_reg_rdata_unused_guard,
	output port_bits_t      o_reg_rdata,
	// pads and sleep
	input  wire port_bits_t i_pad_in,
	input  wire logic       i_sleep,
	output port_bits_t      o_pad_out,
	output port_bits_t      o_pad_oe,
	output port_bits_t      o_pullup_enable,
	// override side
	port_override_if.device ovr
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	port_bits_t pin_direction_reg;
	port_bits_t pin_output_reg;
	port_bits_t pin_output_next;
	port_bits_t mcu_control_reg;
	port_bits_t sync_stage_reg;
	port_bits_t pin_input_reg;
	port_bits_t rdata_reg;
	port_bits_t input_enable;
	port_bits_t gpio_pullup;
	logic       global_pullup_disable;

	// only the pull-up disable bit acts, the other control bits just hold
	assign global_pullup_disable = mcu_control_reg[`MCU_PUD_BIT];

	// ----------------------------------------------------------------
	// per-pin decode helpers
	// ----------------------------------------------------------------
	// bit n of every vector is pin n, so each helper serves all pins
	function automatic port_bits_t override_mux(
		input port_bits_t enable,
		input port_bits_t value,
		input port_bits_t normal
	);
		override_mux = (enable & value) | (~enable & normal);
	endfunction : override_mux

	function automatic logic write_hits(
		input logic       wr,
		input reg_index_t idx,
		input reg_index_t target
	);
		write_hits = wr && (idx == target);
	endfunction : write_hits

	// ----------------------------------------------------------------
	// plain gpio decode
	// ----------------------------------------------------------------
	// only a pulled-up input asks for the pull-up; the global disable
	// beats it on every pin so software can rule pull-ups out at once
	assign gpio_pullup = ~pin_direction_reg & pin_output_reg
		& {`PORT_PINS{~global_pullup_disable}}; // R1 R13

	// ----------------------------------------------------------------
	// direction and control registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_direction_reg <= `PORT_RESET;
		end else if (write_hits(i_reg_write, i_reg_index,
				`REG_PIN_DIRECTION)) begin
			pin_direction_reg <= i_reg_wdata; // R21
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			mcu_control_reg <= `MCU_CONTROL_RESET;
		end else if (write_hits(i_reg_write, i_reg_index,
				`REG_MCU_CONTROL)) begin
			mcu_control_reg <= i_reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// output register with toggles
	// ----------------------------------------------------------------
	// a direct write wins; toggles from software and from the override
	// both apply to the stored bit, and two toggles in one cycle cancel
	always_comb begin
		pin_output_next = pin_output_reg;
		if (write_hits(i_reg_write, i_reg_index, `REG_PIN_OUTPUT)) begin
			pin_output_next = i_reg_wdata;
		end else begin
			if (write_hits(i_reg_write, i_reg_index,
					`REG_PIN_INPUT)) begin
				pin_output_next = pin_output_next ^ i_reg_wdata; // R22
			end
			pin_output_next = pin_output_next
				^ ovr.toggle_override_enable; // R7
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_output_reg <= `PORT_RESET;
		end else begin
			pin_output_reg <= pin_output_next;
		end
	end

	// ----------------------------------------------------------------
	// pad control
	// ----------------------------------------------------------------
	// overrides are flopped at their source, so pad controls settle a
	// cycle after a peripheral decides; the pad itself needs no flop
	always_comb begin
		o_pullup_enable = override_mux(
			ovr.pullup_override_enable,
			ovr.pullup_override_value,
			gpio_pullup); // R1 R2 R13
		o_pad_oe = override_mux(
			ovr.direction_override_enable,
			ovr.direction_override_value,
			pin_direction_reg); // R3 R4
		o_pad_out = override_mux(
			ovr.value_override_enable,
			ovr.value_override_value,
			pin_output_reg) & o_pad_oe; // R5 R6 R14 R15 R16 R17 R19
		input_enable = override_mux(
			ovr.input_enable_override_enable,
			ovr.input_enable_override_value,
			{`PORT_PINS{~i_sleep}}); // R8 R9
	end

	// ----------------------------------------------------------------
	// input path
	// ----------------------------------------------------------------
	// the clamp models the schmitt trigger gate; what leaves here for
	// the peripherals is asynchronous and must be synchronised there
	assign ovr.alt_function_raw_input = i_pad_in & input_enable; // R10 R18

	// two flops guard the register read; nothing else reads the first
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			sync_stage_reg <= `PORT_RESET;
			pin_input_reg  <= `PORT_RESET;
		end else begin
			sync_stage_reg <= ovr.alt_function_raw_input;
			pin_input_reg  <= sync_stage_reg;
		end
	end

	// ----------------------------------------------------------------
	// read back
	// ----------------------------------------------------------------
	// read data comes from a flop, so it trails the index by one edge
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_reg <= `PORT_RESET;
		end else begin
			case (i_reg_index)
				`REG_PIN_INPUT:     rdata_reg <= pin_input_reg;
				`REG_PIN_DIRECTION: rdata_reg <= pin_direction_reg;
				`REG_PIN_OUTPUT:    rdata_reg <= pin_output_reg;
				`REG_MCU_CONTROL:   rdata_reg <= mcu_control_reg;
				default:            rdata_reg <= `PORT_RESET;
			endcase
		end
	end

	assign o_reg_rdata              = rdata_reg;
	assign o_reg_rdata_unused_guard = 1'b0;

endmodule : port_pin_alt_function_override
`default_nettype wire

// file: port_alt_function_peripherals.sv
// peripheral end: builds the override signals for the port pins
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_consts.svh"
module port_alt_function_peripherals
	import port_pin_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic      [31:0] o_prdata,
	// waveforms from the peripheral cores
	input  wire logic        i_timer0_compare_a_out,
	input  wire logic        i_timer1_compare_a_out,
	input  wire logic        i_timer1_compare_b_out,
	input  wire logic        i_timer1_compare_c_out,
	input  wire logic        i_fast_timer_compare_b_out,
	input  wire logic        i_uart_rts_out,
	input  wire logic        i_spi_clock_out,
	input  wire logic        i_spi_data_out,
	// synchronised pin-change sources
	output port_bits_t       o_pin_change_sources,
	// pin side
	port_override_if.peripheral ovr
);

	// ----------------------------------------------------------------
	// apb registers
	// ----------------------------------------------------------------
	logic [6:0]  func_enable_reg;
	port_bits_t  pc_mask_reg;
	logic        pc_enable_reg;
	port_bits_t  raw_sync_reg;
	port_bits_t  raw_pin_reg;
	logic        access;
	logic        mapped;

	assign access   = i_psel && i_penable;
	assign mapped   = (i_paddr == `APB_FUNC_ENABLE)
		|| (i_paddr == `APB_PIN_CHANGE) || (i_paddr == `APB_PIN_STATUS);
	assign o_pready  = 1'b1;
	assign o_pslverr = access && !mapped;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			func_enable_reg <= 7'h00;
			pc_mask_reg     <= 8'h00;
			pc_enable_reg   <= 1'b0;
		end else if (access && i_pwrite) begin
			if (i_paddr == `APB_FUNC_ENABLE) begin
				func_enable_reg <= i_pwdata[6:0];
			end
			if (i_paddr == `APB_PIN_CHANGE) begin
				pc_mask_reg   <= i_pwdata[`PC_MASK_LSB +: 8];
				pc_enable_reg <= i_pwdata[`PC_ENABLE_BIT];
			end
		end
	end

	always_comb begin
		o_prdata = `APB_ZERO;
		if (i_paddr == `APB_FUNC_ENABLE) begin
			o_prdata = {25'h000_0000, func_enable_reg};
		end else if (i_paddr == `APB_PIN_CHANGE) begin
			o_prdata = {23'h00_0000, pc_enable_reg, pc_mask_reg};
		end else if (i_paddr == `APB_PIN_STATUS) begin
			o_prdata = {24'h00_0000, raw_pin_reg};
		end
	end

	// ----------------------------------------------------------------
	// own synchroniser for the raw pin input
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			raw_sync_reg <= 8'h00;
			raw_pin_reg  <= 8'h00;
		end else begin
			raw_sync_reg <= ovr.alt_function_raw_input; // R11
			raw_pin_reg  <= raw_sync_reg;
		end
	end

	assign o_pin_change_sources = raw_pin_reg & pc_mask_reg
		& {8{pc_enable_reg}};

	// ----------------------------------------------------------------
	// override generation, flopped so the pins see clean levels
	// ----------------------------------------------------------------
	// pin 7 sources share one value path: when several are enabled the
	// lower field wins, software is expected to enable only one
	logic spi_master;
	logic p7_enable;
	logic p7_value;
	logic p6_enable;
	logic p6_value;

	assign spi_master = func_enable_reg[`FE_SPI_MASTER];
	assign p7_enable  = func_enable_reg[`FE_TIMER0_A]
		|| func_enable_reg[`FE_TIMER1_C] || func_enable_reg[`FE_RTS];
	assign p7_value   = func_enable_reg[`FE_TIMER0_A]
		? i_timer0_compare_a_out
		: (func_enable_reg[`FE_TIMER1_C]
			? i_timer1_compare_c_out : i_uart_rts_out); // R14 R15 R19
	assign p6_enable  = func_enable_reg[`FE_TIMER1_B]
		|| func_enable_reg[`FE_FAST_B];
	assign p6_value   = func_enable_reg[`FE_TIMER1_B]
		? i_timer1_compare_b_out : i_fast_timer_compare_b_out; // R16 R17

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			ovr.pullup_override_enable      <= 8'h00;
			ovr.pullup_override_value       <= 8'h00;
			ovr.direction_override_enable   <= 8'h00;
			ovr.direction_override_value    <= 8'h00;
			ovr.value_override_enable       <= 8'h00;
			ovr.value_override_value        <= 8'h00;
			ovr.toggle_override_enable      <= 8'h00;
			ovr.input_enable_override_enable <= 8'h00;
			ovr.input_enable_override_value <= 8'h00;
		end else begin
			ovr.pullup_override_enable <= {4'h0, {4{spi_master}}}; // R12 R20
			ovr.pullup_override_value  <= 8'h00;
			ovr.direction_override_enable <= {4'h0, {4{spi_master}}};
			ovr.direction_override_value  <= 8'h00;
			ovr.value_override_enable <= {p7_enable, p6_enable,
				func_enable_reg[`FE_TIMER1_A], 1'b0,
				{3{spi_master}}, 1'b0}; // R20
			ovr.value_override_value <= {p7_value, p6_value,
				i_timer1_compare_a_out, 1'b0, 1'b0,
				i_spi_data_out, i_spi_clock_out, 1'b0};
			ovr.toggle_override_enable <= 8'h00; // R23
			ovr.input_enable_override_enable <= pc_mask_reg
				& {8{pc_enable_reg}}; // R18
			ovr.input_enable_override_value <= 8'hff;
		end
	end

endmodule : port_alt_function_peripherals
`default_nettype wire

// file: port_pin_alt_function_override_assertions.sv
// checker for the port pin outputs and the override interface
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_consts.svh"
module port_pin_alt_function_override_assertions
	import port_pin_pkg::*;
(
	input wire logic       i_clock,
	input wire logic       i_nrst,
	input wire logic       i_reg_write,
	input wire reg_index_t i_reg_index,
	input wire port_bits_t i_reg_wdata,
	input wire logic       i_sleep,
	input wire port_bits_t i_pad_in,
	input wire port_bits_t o_pad_out,
	input wire port_bits_t o_pad_oe,
	input wire port_bits_t o_pullup_enable,
	input wire port_bits_t pullup_override_enable,
	input wire port_bits_t pullup_override_value,
	input wire port_bits_t direction_override_enable,
	input wire port_bits_t direction_override_value,
	input wire port_bits_t value_override_enable,
	input wire port_bits_t value_override_value,
	input wire port_bits_t toggle_override_enable,
	input wire port_bits_t input_enable_override_enable,
	input wire port_bits_t input_enable_override_value,
	input wire port_bits_t alt_function_raw_input
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	port_bits_t ie_oe;
	port_bits_t in_gate;
	assign ie_oe = input_enable_override_enable;
	// sleep only gates pins that no peripheral holds open
	assign in_gate = (ie_oe & input_enable_override_value) |
		(~ie_oe & {8{~i_sleep}});
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);

	a_pullup_override: assert property (
		(o_pullup_enable & pullup_override_enable) ==
		(pullup_override_value & pullup_override_enable))
		else $error("pull-up ignores override");
	a_pullup_off_out: assert property (
		(o_pullup_enable & ~pullup_override_enable & o_pad_oe &
		~direction_override_enable) == 8'h00)
		else $error("pull-up on a driven pin");
	a_driver_override: assert property (
		(o_pad_oe & direction_override_enable) ==
		(direction_override_value & direction_override_enable))
		else $error("driver ignores override");
	a_dir_write_lands: assert property (
		(i_reg_write && i_reg_index == `REG_PIN_DIRECTION) |=>
		((o_pad_oe ^ $past(i_reg_wdata)) &
		~direction_override_enable) == 8'h00)
		else $error("direction write not on driver");
	a_value_override: assert property (
		(o_pad_out & value_override_enable & o_pad_oe) ==
		(value_override_value & value_override_enable & o_pad_oe))
		else $error("pin level ignores override");
	a_pud_kills_pullup: assert property (
		(i_reg_write && i_reg_index == `REG_MCU_CONTROL &&
		i_reg_wdata[`MCU_PUD_BIT]) |=>
		(o_pullup_enable & ~pullup_override_enable) == 8'h00)
		else $error("pull-up survives disable");
	a_raw_input_gate: assert property (
		alt_function_raw_input == (i_pad_in & in_gate))
		else $error("raw input gate wrong");
	a_unused_tied: assert property (
		toggle_override_enable == 8'h00 &&
		pullup_override_enable[7:4] == 4'h0 &&
		direction_override_enable[7:4] == 4'h0)
		else $error("unused override enable active");
	a_toggle_inverts: assert property (
		!i_reg_write |=>
		((o_pad_out ^ $past(o_pad_out) ^ $past(toggle_override_enable))
		& o_pad_oe & $past(o_pad_oe) & ~value_override_enable
		& ~$past(value_override_enable)) == 8'h00)
		else $error("output bit changed without write");
endmodule : port_pin_alt_function_override_assertions
`default_nettype wire

// file: port_pin_alt_function_override_tb.sv
// self-checking bench: both ends joined through the override interface
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_consts.svh"
`define CHK(nm, e, s) \
	begin \
		total_checks++; \
		if ((s) !== (e)) begin \
			n_fail++; \
			$display("[ERR] %s exp %0h got %0h", nm, e, s); \
		end \
	end
module port_pin_alt_function_override_tb
	import port_pin_pkg::*;
;
	logic        i_clock = 1'b0;
	logic        i_nrst = 1'b0;
	logic        i_reg_write = 1'b0;
	reg_index_t  i_reg_index = 2'h0;
	port_bits_t  i_reg_wdata = 8'h00;
	port_bits_t  i_pad_in = 8'h00;
	logic        i_sleep = 1'b0;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0000_0000;
	logic [5:0]  wave = 6'h00;
	logic [1:0]  spi = 2'h0;
	port_bits_t  o_reg_rdata, o_pad_out, o_pad_oe, o_pullup_enable, pcs;
	logic        o_pready, o_pslverr;
	logic [31:0] o_prdata, q;
	port_bits_t  v;
	logic        e;
	int          n_fail = 0;
	int          total_checks = 0;
	int          pin_of [6] = '{7, 7, 6, 6, 7, 5};

	port_override_if ovr ();
	always #50 i_clock = ~i_clock;

	port_pin_alt_function_override port_pin_alt_function_override_inst (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_reg_write(i_reg_write),
		.i_reg_index(i_reg_index), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata_unused_guard(), .o_reg_rdata(o_reg_rdata),
		.i_pad_in(i_pad_in), .i_sleep(i_sleep), .o_pad_out(o_pad_out),
		.o_pad_oe(o_pad_oe), .o_pullup_enable(o_pullup_enable), .ovr(ovr));
	port_alt_function_peripherals port_alt_function_peripherals_inst (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.o_prdata(o_prdata), .i_timer0_compare_a_out(wave[0]),
		.i_timer1_compare_c_out(wave[1]), .i_timer1_compare_b_out(wave[2]),
		.i_fast_timer_compare_b_out(wave[3]), .i_uart_rts_out(wave[4]),
		.i_timer1_compare_a_out(wave[5]), .i_spi_clock_out(spi[0]),
		.i_spi_data_out(spi[1]), .o_pin_change_sources(pcs), .ovr(ovr));
	port_pin_alt_function_override_assertions
		port_pin_alt_function_override_assertions_inst (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_reg_write(i_reg_write),
		.i_reg_index(i_reg_index), .i_reg_wdata(i_reg_wdata),
		.i_sleep(i_sleep), .i_pad_in(i_pad_in), .o_pad_out(o_pad_out),
		.o_pad_oe(o_pad_oe), .o_pullup_enable(o_pullup_enable),
		.pullup_override_enable(ovr.pullup_override_enable),
		.pullup_override_value(ovr.pullup_override_value),
		.direction_override_enable(ovr.direction_override_enable),
		.direction_override_value(ovr.direction_override_value),
		.value_override_enable(ovr.value_override_enable),
		.value_override_value(ovr.value_override_value),
		.toggle_override_enable(ovr.toggle_override_enable),
		.input_enable_override_enable(ovr.input_enable_override_enable),
		.input_enable_override_value(ovr.input_enable_override_value),
		.alt_function_raw_input(ovr.alt_function_raw_input));

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task automatic wr(input reg_index_t x, input port_bits_t d);
		@(posedge i_clock);
		i_reg_write <= 1'b1;
		i_reg_index <= x;
		i_reg_wdata <= d;
		@(posedge i_clock);
		i_reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input reg_index_t x, output port_bits_t d);
		@(posedge i_clock);
		i_reg_index <= x;
		repeat (2) @(posedge i_clock);
		@(negedge i_clock);
		d = o_reg_rdata;
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge i_clock);
		@(negedge i_clock);
	endtask : idle
	// the slave answers at once, but no wait count is assumed
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic x);
		int n;
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge i_clock);
			if (o_pready === 1'b1)
				break;
		end
		r = o_prdata;
		x = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		if (n == 16) begin
			n_fail++;
			complete_run();
		end
	endtask : apb

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge i_clock);
		i_nrst <= 1'b1;
		idle(1);
		`CHK("pad_oe", 8'h00, o_pad_oe);
		rd(`REG_MCU_CONTROL, v);
		`CHK("mcu_control", `MCU_CONTROL_RESET, v);
		$display("test reset done");
		wr(`REG_PIN_DIRECTION, 8'hF0);
		wr(`REG_PIN_OUTPUT, 8'hAA);
		idle(1);
		`CHK("pad_oe", 8'hF0, o_pad_oe);
		`CHK("pad_out", 8'hA0, o_pad_out);
		`CHK("pullup", 8'h0A, o_pullup_enable);
		wr(`REG_MCU_CONTROL, 8'h10);
		idle(1);
		`CHK("pullup", 8'h00, o_pullup_enable);
		wr(`REG_MCU_CONTROL, 8'h00);
		wr(`REG_PIN_INPUT, 8'hFF);
		idle(1);
		`CHK("pad_out", 8'h50, o_pad_out);
		`CHK("pullup", 8'h05, o_pullup_enable);
		$display("test gpio done");
		@(posedge i_clock);
		i_pad_in <= 8'hC3;
		idle(3);
		`CHK("raw", 8'hC3, ovr.alt_function_raw_input);
		rd(`REG_PIN_INPUT, v);
		`CHK("pin_input", 8'hC3, v);
		@(posedge i_clock);
		i_sleep <= 1'b1;
		idle(1);
		`CHK("raw", 8'h00, ovr.alt_function_raw_input);
		apb(1'b1, `APB_PIN_CHANGE, 32'h0000_01C0, q, e);
		idle(3);
		`CHK("raw", 8'hC0, ovr.alt_function_raw_input);
		`CHK("sources", 8'hC0, pcs);
		apb(1'b0, `APB_PIN_STATUS, 32'h0000_0000, q, e);
		`CHK("status", 32'h0000_00C0, q);
		$display("test inputs done");
		wr(`REG_PIN_DIRECTION, 8'hFF);
		for (int k = 0; k < 6; k++) begin
			apb(1'b1, `APB_FUNC_ENABLE, 32'h0000_0001 << k, q, e);
			for (int b = 1; b >= 0; b--) begin
				@(posedge i_clock);
				wave <= b[0] ? 6'h01 << k : 6'h00;
				idle(3);
				`CHK("ovr_en", 1'b1, ovr.value_override_enable[pin_of[k]]);
				`CHK("pin", b[0], o_pad_out[pin_of[k]]);
			end
		end
		apb(1'b1, `APB_FUNC_ENABLE, 32'h0000_0040, q, e);
		@(posedge i_clock);
		spi <= 2'h3;
		idle(3);
		`CHK("pad_oe", 8'hF0, o_pad_oe);
		`CHK("pad_out", 8'h50, o_pad_out);
		`CHK("spi_val", 2'h3, ovr.value_override_value[2:1]);
		wr(`REG_PIN_DIRECTION, 8'hF0);
		idle(1);
		`CHK("pullup", 8'h00, o_pullup_enable);
		$display("test alternates done");
		apb(1'b1, 12'h00C, 32'h0000_FFFF, q, e);
		`CHK("slverr", 1'b1, e);
		apb(1'b0, `APB_FUNC_ENABLE, 32'h0000_0000, q, e);
		`CHK("func_enable", 32'h0000_0040, q);
		apb(1'b0, 12'h00C, 32'h0000_0000, q, e);
		`CHK("unmapped", 32'h0000_0000, q);
		$display("test apb done");
		complete_run();
	end
endmodule : port_pin_alt_function_override_tb
`default_nettype wire
